// ---- mcec_pkg.sv ----
// Purpose: Shared constants and carrier types for the check error code block
// Assumes: One core clock, asynchronous active-high reset
// Notes:   Code values and field positions live here only

package mcec_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Identification and capability bit positions
	localparam int ID_ARCH_BIT      = 14; // Feature word: architecture present
	localparam int ID_EXC_BIT       = 7;  // Feature word: exception present
	localparam int CAP_TRACK_BIT    = 11; // Capability: per-line tracking
	localparam int CAP_COUNT_W      = 8;  // Capability: bank count field width

	////////////////////////////////////////////////////////////////////////////
	// Simple code values
	localparam logic [15:0] CODE_NONE      = 16'h0000;
	localparam logic [15:0] CODE_UNCLASS   = 16'h0001;
	localparam logic [15:0] CODE_UROM_PAR  = 16'h0002;
	localparam logic [15:0] CODE_EXT_INIT  = 16'h0003;
	localparam logic [15:0] CODE_REDUND    = 16'h0004;
	localparam logic [15:0] CODE_INT_PAR   = 16'h0005;
	localparam logic [15:0] CODE_MGMT_RNG  = 16'h0006;
	localparam logic [15:0] CODE_TIMER     = 16'h0400;
	localparam logic [15:0] CODE_IO        = 16'h0E0B;
	localparam logic [5:0]  INT_UNCL_HI    = 6'h01;   // Top six bits, internal

	////////////////////////////////////////////////////////////////////////////
	// Compound code field positions
	localparam int FILTER_BIT       = 12;
	localparam int BUS_BIT          = 11;
	localparam int EXTMEM_BIT       = 9;
	localparam int CACHE_BIT        = 8;
	localparam int MEMCTL_BIT       = 7;
	localparam int TLB_BIT          = 4;
	localparam logic [1:0] GEN_CACHE_TAG = 2'h3;      // Bits 3:2 of generic cache

	////////////////////////////////////////////////////////////////////////////
	// Status word layout: valid, uncorrected, filter-capable code
	localparam int STAT_VALID_BIT   = 63;
	localparam int STAT_UNC_BIT     = 61;
	localparam logic [63:0] STAT_RESET = 64'h0000_0000_0000_0000;

	// Error classes that the detectors may report
	typedef enum logic [3:0] {
		MCEC_K_UNCLASS,
		MCEC_K_UROM_PAR,
		MCEC_K_EXT_INIT,
		MCEC_K_REDUND,
		MCEC_K_INT_PAR,
		MCEC_K_MGMT_RNG,
		MCEC_K_TIMER,
		MCEC_K_IO,
		MCEC_K_INT_UNCL,
		MCEC_K_GEN_CACHE,
		MCEC_K_TLB,
		MCEC_K_MEMCTL,
		MCEC_K_CACHE,
		MCEC_K_EXTMEM,
		MCEC_K_BUS
	} mcec_kind_t;

	// Attributes of one detected error
	typedef struct packed {
		mcec_kind_t  kind;
		logic        uncorrected;   // Uncorrected flag
		logic [1:0]  level;         // Hierarchy level field
		logic [1:0]  txn;           // Transaction type field
		logic [3:0]  request;       // Request kind field
		logic [2:0]  mem_txn;       // Memory transaction type field
		logic [3:0]  channel;       // Channel field
		logic [1:0]  particip;      // Participation field
		logic        timeout;       // Timeout bit
		logic [1:0]  mem_or_io;     // Memory-or-I/O field
		logic [9:0]  internal;      // Low bits of internal unclassified
		logic [15:0] line_tag;      // Identity of the line or entry
	} mcec_err_t;

endpackage : mcec_pkg

// ---- mcec_compose.sv ----
// Purpose: Combinational builder of the 16-bit architectural error code
// Assumes: Attributes valid in the cycle they are presented
// Notes:   Filter bit only applies to compound forms

`timescale 1ns/10ps
`default_nettype none

module mcec_compose (
	// Error attributes
	input  wire mcec_pkg::mcec_err_t i_err,
	input  wire logic                i_filter,
	// Composed code
	output logic [15:0]              o_code
);

	////////////////////////////////////////////////////////////////////////////
	// Code selection by class
	always_comb begin
		o_code = mcec_pkg::CODE_NONE;
		unique case (i_err.kind)
			mcec_pkg::MCEC_K_UNCLASS:  o_code = mcec_pkg::CODE_UNCLASS;
			mcec_pkg::MCEC_K_UROM_PAR: o_code = mcec_pkg::CODE_UROM_PAR;
			mcec_pkg::MCEC_K_EXT_INIT: o_code = mcec_pkg::CODE_EXT_INIT;
			mcec_pkg::MCEC_K_REDUND:   o_code = mcec_pkg::CODE_REDUND;
			mcec_pkg::MCEC_K_INT_PAR:  o_code = mcec_pkg::CODE_INT_PAR;
			mcec_pkg::MCEC_K_MGMT_RNG: o_code = mcec_pkg::CODE_MGMT_RNG;
			mcec_pkg::MCEC_K_TIMER:    o_code = mcec_pkg::CODE_TIMER;
			mcec_pkg::MCEC_K_IO:       o_code = mcec_pkg::CODE_IO;
			mcec_pkg::MCEC_K_INT_UNCL: begin
				// Zero low bits would alias the timer code, so force bit 0
				o_code = {mcec_pkg::INT_UNCL_HI,
				          (i_err.internal == 10'h000) ? 10'h001 : i_err.internal};
			end
			mcec_pkg::MCEC_K_GEN_CACHE: begin
				o_code = 16'h0000;
				o_code[3:2] = mcec_pkg::GEN_CACHE_TAG;
				o_code[1:0] = i_err.level;
			end
			mcec_pkg::MCEC_K_TLB: begin
				o_code = 16'h0000;
				o_code[mcec_pkg::TLB_BIT] = 1'b1;
				o_code[3:0] = {i_err.txn, i_err.level};
			end
			mcec_pkg::MCEC_K_CACHE: begin
				o_code = 16'h0000;
				o_code[mcec_pkg::CACHE_BIT] = 1'b1;
				o_code[7:0] = {i_err.request, i_err.txn, i_err.level};
			end
			mcec_pkg::MCEC_K_MEMCTL, mcec_pkg::MCEC_K_EXTMEM: begin
				o_code = 16'h0000;
				o_code[mcec_pkg::MEMCTL_BIT] = 1'b1;
				o_code[6:0] = {i_err.mem_txn, i_err.channel};
				o_code[mcec_pkg::EXTMEM_BIT] =
					(i_err.kind == mcec_pkg::MCEC_K_EXTMEM);
			end
			mcec_pkg::MCEC_K_BUS: begin
				o_code = 16'h0000;
				o_code[mcec_pkg::BUS_BIT] = 1'b1;
				o_code[10:0] = {i_err.particip, i_err.timeout, i_err.request,
				                i_err.mem_or_io, i_err.level};
			end
			default: o_code = mcec_pkg::CODE_UNCLASS;   // Illegal class code
		endcase
		// Compound forms carry the correction filter bit
		if (i_err.kind inside {mcec_pkg::MCEC_K_GEN_CACHE, mcec_pkg::MCEC_K_TLB,
		                       mcec_pkg::MCEC_K_CACHE, mcec_pkg::MCEC_K_MEMCTL,
		                       mcec_pkg::MCEC_K_EXTMEM, mcec_pkg::MCEC_K_BUS}) begin
			o_code[mcec_pkg::FILTER_BIT] = i_filter;
		end
	end

endmodule : mcec_compose

`default_nettype wire

// ---- mcec_filter.sv ----
// Purpose: Per-line tracker of repeated corrections
// Assumes: One correction event per cycle at most
// Notes:   Small fully associative table, oldest slot replaced

`timescale 1ns/10ps
`default_nettype none

module mcec_filter #(
	parameter int SLOTS     = 4,  // Lines tracked at once
	parameter int THRESHOLD = 2   // Corrections posted before filtering
) (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// Event in
	input  wire logic        i_event,
	input  wire logic        i_uncorrected,
	input  wire logic [15:0] i_line,
	input  wire logic        i_enable,
	// Decision
	output logic             o_post,
	output logic             o_filter_now
);

	localparam int CW = $clog2(THRESHOLD + 1) + 1;
	localparam int IW = (SLOTS > 1) ? $clog2(SLOTS) : 1;

	logic [15:0]   tag   [SLOTS];  // Tracked line identities
	logic          used  [SLOTS];  // Slot holds a line
	logic [CW-1:0] count [SLOTS];  // Corrections seen for the line
	logic [IW-1:0] victim;         // Round-robin replacement pointer
	logic          hit;
	logic [IW-1:0] hit_idx;

	////////////////////////////////////////////////////////////////////////////
	// Lookup
	always_comb begin
		hit     = 1'b0;
		hit_idx = '0;
		for (int s = 0; s < SLOTS; s++) begin
			if (used[s] && tag[s] == i_line && !hit) begin
				hit     = 1'b1;
				hit_idx = IW'(s);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Decision: uncorrected always posts, repeats beyond threshold drop
	always_comb begin
		o_post       = 1'b1;
		o_filter_now = 1'b0;
		if (i_enable && !i_uncorrected) begin
			if (hit && count[hit_idx] >= CW'(THRESHOLD)) begin
				o_post = 1'b0;
			end
			// The last posted correction announces that filtering starts
			o_filter_now = hit ? (count[hit_idx] == CW'(THRESHOLD - 1))
			                   : (THRESHOLD == 1);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Table update on corrected events
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			victim <= '0;
			for (int s = 0; s < SLOTS; s++) begin
				tag[s]   <= 16'h0000;
				used[s]  <= 1'b0;
				count[s] <= '0;
			end
		end else if (i_event && i_enable && !i_uncorrected) begin
			if (hit) begin
				// Saturate so the counter never wraps back to posting
				if (count[hit_idx] < CW'(THRESHOLD)) begin
					count[hit_idx] <= count[hit_idx] + CW'(1);
				end
			end else begin
				tag[victim]   <= i_line;
				used[victim]  <= 1'b1;
				count[victim] <= CW'(1);
				victim        <= (victim == IW'(SLOTS - 1)) ? '0 : victim + IW'(1);
			end
		end
	end

endmodule : mcec_filter

`default_nettype wire

// ---- mcec_top.sv ----
// Purpose: Error code logging into status banks, with exception request
// Assumes: Detectors present one error attribute set per cycle
// Notes:   Software clears status through the clear strobe port

`timescale 1ns/10ps
`default_nettype none

module mcec_top #(
	parameter int BANKS     = 4,  // Error-reporting banks
	parameter int SLOTS     = 4,  // Lines tracked by the filter
	parameter int THRESHOLD = 2   // Corrections posted per line
) (
	// Clock and reset
	input  wire logic                I_CLK,
	input  wire logic                I_RST,
	// Detected error
	input  wire logic                I_ERR_VALID,
	input  wire logic [$clog2(BANKS)-1:0] I_ERR_BANK,
	input  wire mcec_pkg::mcec_err_t I_ERR,
	// Bus-init pin and power-on strap
	input  wire logic                I_BUS_INIT,
	input  wire logic                I_INIT_OBSERVE_STRAP,
	// Software controls
	input  wire logic                I_EXC_ENABLE,
	input  wire logic [BANKS-1:0]    I_BANK_ENABLE,
	input  wire logic [BANKS-1:0]    I_STATUS_CLEAR,
	input  wire logic                I_FILTER_ENABLE,
	// Identification and capability
	output logic [31:0]              O_FEATURE_WORD,
	output logic [31:0]              O_CAPABILITY,
	// Bank status
	output logic [BANKS-1:0][63:0]   O_BANK_STATUS,
	// Exception request
	output logic                     O_CHECK_EXC
);

	localparam int BW = $clog2(BANKS);

	////////////////////////////////////////////////////////////////////////////
	// Internal signals
	logic [15:0] code;           // Code composed this cycle
	logic        post;           // Filter allows posting
	logic        filter_now;     // Filtering starts with this posting
	logic        strap;          // Strap caught after reset release
	logic        strap_taken;    // Strap capture done
	logic        init_prev;      // Last sample of bus-init pin
	logic        init_event;     // Bus-init rising edge
	logic        init_allowed;   // Bus-init may raise an exception
	logic        log_now;        // Error written this cycle
	logic [BW-1:0] log_bank;     // Bank written this cycle
	mcec_pkg::mcec_err_t log_err;

	////////////////////////////////////////////////////////////////////////////
	// Bus-init takes priority; it becomes an external-error record in bank 0
	assign init_event   = I_BUS_INIT && !init_prev;
	assign init_allowed = init_event && strap && I_EXC_ENABLE;

	always_comb begin
		log_err  = I_ERR;
		log_bank = I_ERR_BANK;
		if (init_allowed) begin
			log_err          = '0;
			log_err.kind     = mcec_pkg::MCEC_K_EXT_INIT;
			log_err.uncorrected = 1'b1;
			log_bank         = '0;
		end
	end

	// Only enabled banks log; a filtered correction is not posted
	assign log_now = (init_allowed || (I_ERR_VALID && post))
	                 && I_BANK_ENABLE[log_bank];

	////////////////////////////////////////////////////////////////////////////
	// Code composer
	mcec_compose u_compose (
		.i_err    (log_err),
		.i_filter (filter_now),
		.o_code   (code)
	);

	////////////////////////////////////////////////////////////////////////////
	// Repeated-correction tracker; every corrected offer of any kind names a line by its line tag
	mcec_filter #(
		.SLOTS     (SLOTS),
		.THRESHOLD (THRESHOLD)
	) u_filter (
		.i_clk         (I_CLK),
		.i_rst         (I_RST),
		.i_event       (I_ERR_VALID && !init_allowed),
		.i_uncorrected (I_ERR.uncorrected),
		.i_line        (I_ERR.line_tag),
		.i_enable      (I_FILTER_ENABLE),
		.o_post        (post),
		.o_filter_now  (filter_now)
	);

	////////////////////////////////////////////////////////////////////////////
	// Strap capture: sampled on the first edge after reset release
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			strap       <= 1'b0;
			strap_taken <= 1'b0;
		end else if (!strap_taken) begin
			strap       <= I_INIT_OBSERVE_STRAP;
			strap_taken <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus-init edge history
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			init_prev <= 1'b0;
		end else begin
			init_prev <= I_BUS_INIT;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Identification and capability words are constant after reset
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_FEATURE_WORD <= 32'h0000_0000;
			O_CAPABILITY   <= 32'h0000_0000;
		end else begin
			O_FEATURE_WORD <= 32'h0000_0000;
			O_FEATURE_WORD[mcec_pkg::ID_ARCH_BIT] <= 1'b1;
			O_FEATURE_WORD[mcec_pkg::ID_EXC_BIT]  <= 1'b1;
			O_CAPABILITY <= 32'h0000_0000;
			O_CAPABILITY[mcec_pkg::CAP_COUNT_W-1:0] <= mcec_pkg::CAP_COUNT_W'(BANKS);
			O_CAPABILITY[mcec_pkg::CAP_TRACK_BIT]   <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bank status: write wins over a clear in the same cycle
	// Status is zero from reset; software still clears it at power-up
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			for (int b = 0; b < BANKS; b++) begin
				O_BANK_STATUS[b] <= mcec_pkg::STAT_RESET;
			end
		end else begin
			for (int b = 0; b < BANKS; b++) begin
				if (log_now && log_bank == BW'(b)) begin
					// Code field alone carries the error kind
					O_BANK_STATUS[b] <= mcec_pkg::STAT_RESET;
					O_BANK_STATUS[b][15:0] <= code;
					O_BANK_STATUS[b][mcec_pkg::STAT_UNC_BIT] <= log_err.uncorrected;
					O_BANK_STATUS[b][mcec_pkg::STAT_VALID_BIT] <= 1'b1;
				end else if (I_STATUS_CLEAR[b]) begin
					O_BANK_STATUS[b] <= mcec_pkg::STAT_RESET;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Exception request: one pulse per uncorrected log while enabled
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_CHECK_EXC <= 1'b0;
		end else begin
			O_CHECK_EXC <= log_now && log_err.uncorrected && I_EXC_ENABLE;
		end
	end

endmodule : mcec_top

`default_nettype wire

// ---- mcec_properties.sv ----
// Purpose: Concurrent checks on the error code logging block
// Assumes: One clock domain, reset disables every check
// Notes:   Bank and attributes of the last cycle kept in helper flops

`timescale 1ns/10ps
`default_nettype none

module mcec_properties #(
	parameter int BANKS = 4 // Banks of the checked block
) (
	// Every port of the checked block, as inputs
	input wire logic                      I_CLK,
	input wire logic                      I_RST,
	input wire logic                      I_ERR_VALID,
	input wire logic [$clog2(BANKS)-1:0]  I_ERR_BANK,
	input wire mcec_pkg::mcec_err_t       I_ERR,
	input wire logic                      I_BUS_INIT,
	input wire logic                      I_INIT_OBSERVE_STRAP,
	input wire logic                      I_EXC_ENABLE,
	input wire logic [BANKS-1:0]          I_BANK_ENABLE,
	input wire logic [BANKS-1:0]          I_STATUS_CLEAR,
	input wire logic                      I_FILTER_ENABLE,
	input wire logic [31:0]               O_FEATURE_WORD,
	input wire logic [31:0]               O_CAPABILITY,
	input wire logic [BANKS-1:0][63:0]    O_BANK_STATUS,
	input wire logic                      O_CHECK_EXC
);
	logic [$clog2(BANKS)-1:0] last_bank; // Bank offered last cycle
	mcec_pkg::mcec_err_t      last_err;  // Attributes offered last cycle
	logic [15:0]              code_now;  // Code now in that bank

	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (I_RST);

	////////////////////////////////////////////////////////////////////////////
	// Helper flops, so the properties need no indexed past values
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			last_bank <= '0;
			last_err  <= '0;
		end else begin
			last_bank <= I_ERR_BANK;
			last_err  <= I_ERR;
		end
	end
	assign code_now = O_BANK_STATUS[last_bank][15:0];

	// Offer to an enabled bank with no bus-init edge competing
	sequence s_take;
		I_ERR_VALID && I_BANK_ENABLE[I_ERR_BANK] && !$rose(I_BUS_INIT);
	endsequence
	// Uncorrected offers are never filtered away
	sequence s_take_unc;
		s_take ##0 I_ERR.uncorrected;
	endsequence

	////////////////////////////////////////////////////////////////////////////
	property p_feature;
		!$past(I_RST) |-> O_FEATURE_WORD[14] && O_FEATURE_WORD[7];
	endproperty
	a_feature: assert property (p_feature) else $error("feature bits missing");
	property p_cap;
		!$past(I_RST) |-> O_CAPABILITY[11] && O_CAPABILITY[7:0] == 8'(BANKS);
	endproperty
	a_cap: assert property (p_cap) else $error("capability word wrong");
	property p_log;
		s_take_unc |=> O_BANK_STATUS[last_bank][63] && O_BANK_STATUS[last_bank][61];
	endproperty
	a_log: assert property (p_log) else $error("uncorrected error not logged");
	property p_redund;
		s_take_unc ##0 (I_ERR.kind == mcec_pkg::MCEC_K_REDUND) |=> code_now == 16'h0004;
	endproperty
	a_redund: assert property (p_redund) else $error("redundancy code wrong");
	property p_mgmt;
		s_take_unc ##0 (I_ERR.kind == mcec_pkg::MCEC_K_MGMT_RNG) |=> code_now == 16'h0006;
	endproperty
	a_mgmt: assert property (p_mgmt) else $error("range violation code wrong");
	property p_tlb;
		s_take_unc ##0 (I_ERR.kind == mcec_pkg::MCEC_K_TLB)
			|=> code_now == {12'h001, last_err.txn, last_err.level};
	endproperty
	a_tlb: assert property (p_tlb) else $error("translation code wrong");
	property p_exc;
		s_take_unc ##0 I_EXC_ENABLE |=> O_CHECK_EXC;
	endproperty
	a_exc: assert property (p_exc) else $error("exception request missing");
	property p_exc_off;
		!$past(I_EXC_ENABLE) |-> !O_CHECK_EXC;
	endproperty
	a_exc_off: assert property (p_exc_off) else $error("exception while disabled");
	property p_bus_init;
		$rose(I_BUS_INIT) && I_INIT_OBSERVE_STRAP && I_EXC_ENABLE && I_BANK_ENABLE[0]
			|=> O_BANK_STATUS[0][63] && O_BANK_STATUS[0][15:0] == 16'h0003 && O_CHECK_EXC;
	endproperty
	a_bus_init: assert property (p_bus_init) else $error("bus-init not logged");
	property p_refuse;
		I_ERR_VALID && !I_BANK_ENABLE[I_ERR_BANK] && I_STATUS_CLEAR == '0
			&& !$rose(I_BUS_INIT) |=> $stable(O_BANK_STATUS);
	endproperty
	a_refuse: assert property (p_refuse) else $error("disabled bank changed");
	property p_clear;
		!I_ERR_VALID && !$rose(I_BUS_INIT) && I_STATUS_CLEAR[1] |=> O_BANK_STATUS[1] == 64'h0;
	endproperty
	a_clear: assert property (p_clear) else $error("status not cleared");

endmodule : mcec_properties

bind mcec_top mcec_properties #(.BANKS(BANKS)) u_props (.I_CLK(I_CLK), .I_RST(I_RST),
	.I_ERR_VALID(I_ERR_VALID), .I_ERR_BANK(I_ERR_BANK), .I_ERR(I_ERR),
	.I_BUS_INIT(I_BUS_INIT), .I_INIT_OBSERVE_STRAP(I_INIT_OBSERVE_STRAP),
	.I_EXC_ENABLE(I_EXC_ENABLE), .I_BANK_ENABLE(I_BANK_ENABLE),
	.I_STATUS_CLEAR(I_STATUS_CLEAR), .I_FILTER_ENABLE(I_FILTER_ENABLE),
	.O_FEATURE_WORD(O_FEATURE_WORD), .O_CAPABILITY(O_CAPABILITY),
	.O_BANK_STATUS(O_BANK_STATUS), .O_CHECK_EXC(O_CHECK_EXC));

`default_nettype wire

// ---- mcec_handler_model.sv ----
// Purpose: Software side: bank enables, status clears, handler decode
// Assumes: Every reset of the bench stands for a power-on
// Notes:   Lowest valid bank is the one decoded

`timescale 1ns/10ps
`default_nettype none

module mcec_handler_model #(
	parameter int BANKS = 4 // Banks served
) (
	// Clock and reset
	input  wire logic                   i_clk,
	input  wire logic                   i_rst,
	// Block side
	input  wire logic [BANKS-1:0][63:0] i_status,
	input  wire logic                   i_exc,
	// Scenario requests
	input  wire logic [BANKS-1:0]       i_clear_req,
	input  wire logic [BANKS-1:0]       i_mask_off,
	input  wire logic                   i_exc_on,
	// Controls to the block
	output logic [BANKS-1:0]            o_bank_enable,
	output logic                        o_exc_enable,
	output logic [BANKS-1:0]            o_status_clear,
	// Code seen by the handler
	output logic [15:0]                 o_code
);
	logic pwr_clr; // High until the first edge after reset

	assign o_bank_enable  = ~i_mask_off;
	assign o_exc_enable   = i_exc_on;
	assign o_status_clear = i_clear_req | {BANKS{pwr_clr}};

	////////////////////////////////////////////////////////////////////////////
	// Power-on clear lasts one cycle, before any error may come
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pwr_clr <= 1'b1;
		end else begin
			pwr_clr <= 1'b0;
		end
	end

	// Handler reads the valid flag first; filter bit means nothing if uncorrected
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_code <= 16'h0000;
		end else if (i_exc) begin
			for (int b = BANKS - 1; b >= 0; b--) begin
				if (i_status[b][63]) begin
					o_code <= i_status[b][15:0] & (i_status[b][61] ? 16'hEFFF : 16'hFFFF);
				end
			end
		end
	end

endmodule : mcec_handler_model

`default_nettype wire

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the error code logging block
// Assumes: Fixed one-cycle answer, inputs driven at the falling edge
// Notes:   Field values of every offered error come from mk

`timescale 1ns/10ps
`default_nettype none

module tb_top;
	// Codes expected per error kind, in enum order
	localparam logic [15:0] XC [15] = '{16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005,
		16'h0006, 16'h0400, 16'h0E0B, 16'h06A5, 16'h000E, 16'h0016, 16'h00A5, 16'h0136,
		16'h02A5, 16'h0D3A};
	logic clk = 1'b0; // Known level at time zero, so no false first edge
	logic rst, err_valid, bus_init, strap, filt_en, exc_on, exc_en, exc;
	logic [1:0]        err_bank;
	mcec_pkg::mcec_err_t err;
	logic [3:0]        clr_req, mask_off, bank_en, stat_clr;
	logic [15:0]       h_code;
	logic [31:0]       feat, cap;
	logic [3:0][63:0]  stat;
	int                errors = 0, num_checks = 0;

	mcec_top #(.BANKS(4), .SLOTS(4), .THRESHOLD(2)) DUT (.I_CLK(clk), .I_RST(rst),
		.I_ERR_VALID(err_valid), .I_ERR_BANK(err_bank), .I_ERR(err), .I_BUS_INIT(bus_init),
		.I_INIT_OBSERVE_STRAP(strap), .I_EXC_ENABLE(exc_en), .I_BANK_ENABLE(bank_en),
		.I_STATUS_CLEAR(stat_clr), .I_FILTER_ENABLE(filt_en), .O_FEATURE_WORD(feat),
		.O_CAPABILITY(cap), .O_BANK_STATUS(stat), .O_CHECK_EXC(exc));
	mcec_handler_model #(.BANKS(4)) u_sw (.i_clk(clk), .i_rst(rst), .i_status(stat),
		.i_exc(exc), .i_clear_req(clr_req), .i_mask_off(mask_off), .i_exc_on(exc_on),
		.o_bank_enable(bank_en), .o_exc_enable(exc_en), .o_status_clear(stat_clr),
		.o_code(h_code));

	////////////////////////////////////////////////////////////////////////////
	// Compare helpers
	task chk(input logic [63:0] g, input logic [63:0] e);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task chkb(input logic g, input logic e);
		chk({63'h0, g}, {63'h0, e});
	endtask : chkb
	// Same field values for every kind; the low bits double as line identity
	function mcec_pkg::mcec_err_t mk(input int k, input logic unc, input logic [9:0] low);
		mk = '0;
		mk.kind = mcec_pkg::mcec_kind_t'(k);
		mk.uncorrected = unc;
		mk.level = 2'h2;
		mk.txn = 2'h1;
		mk.request = 4'h3;
		mk.mem_txn = 3'h2;
		mk.channel = 4'h5;
		mk.particip = 2'h2;
		mk.timeout = 1'b1;
		mk.mem_or_io = 2'h2;
		mk.internal = low;
		mk.line_tag = {6'h00, low};
	endfunction : mk
	function logic [63:0] st(input logic unc, input logic [15:0] c);
		st = {1'b1, 1'b0, unc, 45'h0, c};
	endfunction : st
	// Offer one error and judge the answer one cycle later; valid stays up
	task post(input logic [1:0] b, input mcec_pkg::mcec_err_t e, input logic [63:0] xs,
		input logic xe);
		err_valid = 1'b1;
		err_bank = b;
		err = e;
		@(negedge clk);
		chk(stat[b], xs);
		chkb(exc, xe);
	endtask : post
	task reset_dut(input logic s);
		rst = 1'b1;
		strap = s;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		repeat (2) @(negedge clk);
	endtask : reset_dut

	////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task t_ident;
		chk(64'(feat & 32'h0000_4080), 64'h4080);
		chkb(cap[11], 1'b1);
		chk(64'(cap[7:0]), 64'h4);
		chk(stat[2], 64'h0);
	endtask : t_ident
	task t_codes;
		for (int k = 0; k < 15; k++) begin
			post(2'(k), mk(k, 1'b1, 10'h2A5), st(1'b1, XC[k]), 1'b1);
		end
		post(2'h3, mk(8, 1'b1, 10'h000), st(1'b1, 16'h0401), 1'b1);
	endtask : t_codes
	task t_filter;
		filt_en = 1'b1;
		post(2'h1, mk(10, 1'b0, 10'h001), st(1'b0, 16'h0016), 1'b0);
		post(2'h1, mk(10, 1'b0, 10'h001), st(1'b0, 16'h1016), 1'b0);
		err_valid = 1'b0;
		clr_req = 4'h2;
		@(negedge clk);
		clr_req = 4'h0;
		chk(stat[1], 64'h0);
		post(2'h1, mk(10, 1'b0, 10'h001), 64'h0, 1'b0);
		post(2'h1, mk(10, 1'b1, 10'h001), st(1'b1, 16'h0016), 1'b1);
		mask_off = 4'h4;
		post(2'h2, mk(3, 1'b1, 10'h001), st(1'b1, 16'h0D3A), 1'b0);
		err_valid = 1'b0;
		filt_en = 1'b0;
		@(negedge clk);
		mask_off = 4'h0;
	endtask : t_filter
	task t_bus;
		exc_on = 1'b0;
		bus_init = 1'b1;
		@(negedge clk);
		chk(stat[0], st(1'b1, 16'h0136));
		chkb(exc, 1'b0);
		bus_init = 1'b0;
		exc_on = 1'b1;
		@(negedge clk);
		bus_init = 1'b1;
		@(negedge clk);
		chk(stat[0], st(1'b1, 16'h0003));
		chkb(exc, 1'b1);
		bus_init = 1'b0;
		@(negedge clk);
		chk(64'(h_code), 64'h0003);
		reset_dut(1'b0);
		bus_init = 1'b1;
		@(negedge clk);
		chk(stat[0], 64'h0);
		chkb(exc, 1'b0);
		bus_init = 1'b0;
	endtask : t_bus

	////////////////////////////////////////////////////////////////////////////
	// Verdict, reached from the main sequence or the run limit
	task test_done;
		$display("Checks %0d, errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : test_done

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Run limit, far above the few dozen cycles needed
	initial begin
		repeat (3000) @(posedge clk);
		errors++;
		$display("Run limit reached at %0t", $time);
		test_done();
	end
	initial begin
		{err_valid, err_bank, err, bus_init, filt_en, clr_req, mask_off} = '0;
		exc_on = 1'b1;
		reset_dut(1'b1);
		t_ident();
		t_codes();
		t_filter();
		t_bus();
		test_done();
	end
endmodule : tb_top

`default_nettype wire
